// File: tsd_time_scale_divider.sv
// Purpose: Main and auxiliary decade dividers, offset capture, sync reset, deviation gate, modulation divider
// Assumes: refTick and hfTick are one-cycle strobes from logic on this clock; extPulse, multPulse are pins
// Notes:   What this block does is listed below; ce low freezes every flip-flop
//
// What this block does
// [RL1] Both time scales divide the 10 MHz reference
// [RL2] Auxiliary divider counts every reference tick while ce is high, in every mode
// [RL3] Main divider gated only in deviation measurement
// [RL4] Time-of-day mode shows time counter, 1 Hz
// [RL5] Offset mode captures main divider on pulse
// [RL6] Sync mode pulse resets all main decades
// [RL7] Gate pulse spans ten multiplier output ticks
// [RL8] Main divider counts reference ticks while gated
// [RL9] Gate end closes main divider input
// [RL10] After gate closes, store divider into memory
// [RL11] Deviation mode shows the memory block
// [RL12] After store, clear main divider to zero
// [RL13] Then preset output divider to nine, restart
// [RL14] Three cascaded dividers make 86.8 Hz reference
// [RL15] Main divider wraps 9999999 to zero, pulse
// [RL16] Sync reset: short fast, long slow decades
// [RL17] Memory holds value until next capture
`timescale 1ns/1ps

module tsd_time_scale_divider #(
	parameter int DECADES = tsd_pkg::DECADE_COUNT,
	parameter int DIV_A   = tsd_pkg::MOD_DIV_A,
	parameter int DIV_B   = tsd_pkg::MOD_DIV_B,
	parameter int DIV_C   = tsd_pkg::MOD_DIV_C
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    ce,
	input  wire tsd_pkg::tsd_mode_type   mode,
	input  wire logic                    pulseSourceSelect,
	input  wire logic                    refTick,
	input  wire logic                    hfTick,
	input  wire logic                    extPulse,
	input  wire logic                    multPulse,
	input  wire logic [23:0]             timeCounterValue,
	output logic                         mainScalePulse,
	output logic                         auxScalePulse,
	output logic                         timeCounterTick,
	output logic [DECADES*4-1:0]         displayValue,
	output tsd_pkg::tsd_status_type      status,
	output tsd_pkg::tsd_modulation_type  modulation
);
	import tsd_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (DECADES < 1 || DECADES > DECADE_COUNT) begin : g_bad_decades
		$error("DECADES out of range");
	end
	if (DIV_A < 2 || DIV_B < 2 || DIV_C < 4 || DIV_C > 255 || DIV_A > 255 || DIV_B > 255) begin : g_bad_div
		$error("Modulation divider ratios out of range");
	end

	localparam logic [MOD_CNT_WIDTH-1:0] A_LAST   = MOD_CNT_WIDTH'(DIV_A - 1);
	localparam logic [MOD_CNT_WIDTH-1:0] B_LAST   = MOD_CNT_WIDTH'(DIV_B - 1);
	localparam logic [MOD_CNT_WIDTH-1:0] C_LAST   = MOD_CNT_WIDTH'(DIV_C - 1);
	localparam logic [MOD_CNT_WIDTH-1:0] C_HALF   = MOD_CNT_WIDTH'(DIV_C / 2);
	localparam logic [HOLD_WIDTH-1:0]    FAST_LEN = HOLD_WIDTH'(FAST_RESET_CYCLES);
	localparam logic [HOLD_WIDTH-1:0]    SLOW_LEN = HOLD_WIDTH'(SLOW_RESET_CYCLES);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] extSync;
	logic [2:0] multSync;
	logic       extRise;
	logic       multRise;

	// Edge detectors look only at stages two and three, never the first flop
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			extSync  <= 3'h0;
			multSync <= 3'h0;
		end else if (ce) begin
			extSync  <= {extSync[1:0], extPulse};
			multSync <= {multSync[1:0], multPulse};
		end
	end

	assign extRise  = extSync[1] & ~extSync[2];
	assign multRise = multSync[1] & ~multSync[2];

	// ****************************************
	// Auxiliary divider
	// ****************************************
	logic [DECADES-1:0][3:0] auxDigit;
	logic [DECADES:0]        auxCarry;
	logic                    selPulse;

	assign auxCarry[0] = refTick;  // see [RL2]

	for (genvar i = 0; i < DECADES; i++) begin : g_aux
		assign auxCarry[i+1] = auxCarry[i] && (auxDigit[i] == DIGIT_MAX);
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				auxDigit[i] <= DIGIT_ZERO;
			end else if (ce && auxCarry[i]) begin
				auxDigit[i] <= (auxDigit[i] == DIGIT_MAX) ? DIGIT_ZERO : auxDigit[i] + 4'h1;  // see [RL1]
			end
		end
	end

	assign selPulse = pulseSourceSelect ? auxScalePulse : extRise;

	// ****************************************
	// Measurement sequencer
	// ****************************************
	tsd_meas_state_type measState;
	logic [3:0]         outDiv;
	logic               outRoll;
	logic               gateOpen;
	logic               measDone;
	logic               freqMode;

	assign freqMode = (mode == MODE_FREQ_DEVIATION);
	assign outRoll  = multRise && (outDiv == DIGIT_MAX);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			measState <= MEAS_IDLE;
		end else if (ce) begin
			if (!freqMode) begin
				measState <= MEAS_IDLE;
			end else begin
				unique case (measState)
					MEAS_IDLE:   measState <= MEAS_CLEAR;
					MEAS_CLEAR:  measState <= MEAS_PRESET;
					MEAS_PRESET: measState <= MEAS_ARMED;
					MEAS_ARMED: begin
						if (outRoll) begin
							measState <= MEAS_GATING;  // see [RL13]
						end
					end
					MEAS_GATING: begin
						if (outRoll) begin
							measState <= MEAS_STORE;  // see [RL9]
						end
					end
					MEAS_STORE:  measState <= MEAS_CLEAR;  // see [RL12]
				endcase
			end
		end
	end

	// Output divider of the multiplier: ten input ticks make one gate period
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			outDiv <= DIGIT_ZERO;
		end else if (ce) begin
			if (measState == MEAS_PRESET) begin
				outDiv <= OUT_DIV_PRESET;  // see [RL13]
			end else if (multRise) begin
				outDiv <= (outDiv == DIGIT_MAX) ? DIGIT_ZERO : outDiv + 4'h1;  // see [RL7]
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gateOpen <= 1'b0;
		end else if (ce) begin
			if (!freqMode) begin
				gateOpen <= 1'b0;
			end else if (measState == MEAS_ARMED && outRoll) begin
				gateOpen <= 1'b1;  // see [RL7]
			end else if (measState == MEAS_GATING && outRoll) begin
				gateOpen <= 1'b0;  // see [RL9]
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			measDone <= 1'b0;
		end else if (ce) begin
			measDone <= (measState == MEAS_STORE);
		end
	end

	// ****************************************
	// Synchronising reset stretchers
	// ****************************************
	logic                  syncPulse;
	logic [HOLD_WIDTH-1:0] fastHold;
	logic [HOLD_WIDTH-1:0] slowHold;

	assign syncPulse = (mode == MODE_SYNCHRONISE) && selPulse;

	// Fast decade is only briefly cleared; slow decades need the longer pulse to settle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fastHold <= '0;
			slowHold <= '0;
		end else if (ce) begin
			if (syncPulse) begin
				fastHold <= FAST_LEN;  // see [RL16]
				slowHold <= SLOW_LEN;  // see [RL16]
			end else begin
				fastHold <= (fastHold != '0) ? fastHold - 1'b1 : fastHold;
				slowHold <= (slowHold != '0) ? slowHold - 1'b1 : slowHold;
			end
		end
	end

	// ****************************************
	// Main divider
	// ****************************************
	logic [DECADES-1:0][3:0] mainDigit;
	logic [DECADES:0]        mainCarry;
	logic                    mainClear;
	logic                    fastClr;
	logic                    slowClr;

	// Gate is forced open outside deviation measurement
	assign mainCarry[0] = refTick && (!freqMode || gateOpen);  // see [RL3] see [RL8]
	assign mainClear    = (measState == MEAS_CLEAR);  // see [RL12]
	assign fastClr      = syncPulse || (fastHold != '0);  // see [RL6]
	assign slowClr      = syncPulse || (slowHold != '0);  // see [RL6]

	for (genvar i = 0; i < DECADES; i++) begin : g_main
		assign mainCarry[i+1] = mainCarry[i] && (mainDigit[i] == DIGIT_MAX);
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				mainDigit[i] <= DIGIT_ZERO;
			end else if (ce) begin
				if (mainClear || (i == 0 ? fastClr : slowClr)) begin
					mainDigit[i] <= DIGIT_ZERO;  // see [RL6]
				end else if (mainCarry[i]) begin
					mainDigit[i] <= (mainDigit[i] == DIGIT_MAX) ? DIGIT_ZERO : mainDigit[i] + 4'h1;  // see [RL15]
				end
			end
		end
	end

	// ****************************************
	// Memory block
	// ****************************************
	logic [DECADES-1:0][3:0] memValue;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			memValue <= '0;
		end else if (ce) begin
			if (mode == MODE_SCALE_OFFSET_MEASURE && selPulse) begin
				memValue <= mainDigit;  // see [RL5]
			end else if (measState == MEAS_STORE) begin
				memValue <= mainDigit;  // see [RL10]
			end
			// Otherwise held so the display stays still, see [RL17]
		end
	end

	// ****************************************
	// Scale pulses and display routing
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mainScalePulse  <= 1'b0;
			auxScalePulse   <= 1'b0;
			timeCounterTick <= 1'b0;
		end else if (ce) begin
			mainScalePulse  <= mainCarry[DECADES];  // see [RL15]
			auxScalePulse   <= auxCarry[DECADES];  // see [RL1]
			timeCounterTick <= mainCarry[DECADES] && (mode == MODE_TIME_OF_DAY);  // see [RL4]
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			displayValue <= '0;
		end else if (ce) begin
			if (mode == MODE_TIME_OF_DAY) begin
				// Fewer than six decades drop the upper time digits
				displayValue <= (DECADES*4)'({{(DECADES*4){1'b0}}, timeCounterValue});  // see [RL4]
			end else begin
				displayValue <= memValue;  // see [RL11] see [RL5]
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status <= '0;
		end else if (ce) begin
			status.gateOpen   <= !freqMode || gateOpen;
			status.measBusy   <= freqMode && (measState != MEAS_ARMED);
			status.measDone   <= measDone;
			status.syncActive <= fastClr || slowClr;
		end
	end

	// ****************************************
	// Modulation reference dividers
	// ****************************************
	logic [MOD_CNT_WIDTH-1:0] divA;
	logic [MOD_CNT_WIDTH-1:0] divB;
	logic [MOD_CNT_WIDTH-1:0] divC;
	logic                     carryA;
	logic                     carryB;

	assign carryA = hfTick && (divA == A_LAST);
	assign carryB = carryA && (divB == B_LAST);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			divA <= '0;
			divB <= '0;
			divC <= '0;
		end else if (ce) begin
			if (hfTick) begin
				divA <= carryA ? '0 : divA + 1'b1;  // see [RL14]
			end
			if (carryA) begin
				divB <= (divB == B_LAST) ? '0 : divB + 1'b1;  // see [RL14]
			end
			if (carryB) begin
				divC <= (divC == C_LAST) ? '0 : divC + 1'b1;  // see [RL14]
			end
		end
	end

	// Square wave for the detector; phase word feeds the sine shaper outside
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			modulation <= '0;
		end else if (ce) begin
			modulation.refSquare <= (divC < C_HALF);  // see [RL14]
			modulation.modPhase  <= divC;
		end
	end

endmodule

// File: tsd_pkg.sv
// Purpose: Shared types and constants for the time-scale divider and measurement block
// Assumes: 25 MHz system clock; 10 MHz and multiplier events arrive as strobes or pins
// Notes:   Times are held in nanoseconds and converted to clock cycles here
package tsd_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_PERIOD_NS   = 40;
	// Reset pulse lengths are least times, so the cycle counts round up
	localparam int FAST_RESET_NS     = 40;
	localparam int SLOW_RESET_NS     = 600;
	localparam int FAST_RESET_CYCLES = (FAST_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SLOW_RESET_CYCLES = (SLOW_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int HOLD_WIDTH        = 5;

	// ****************************************
	// Divider constants
	// ****************************************
	localparam int         DECADE_COUNT   = 7;
	localparam logic [3:0] DIGIT_MAX      = 4'h9;
	localparam logic [3:0] DIGIT_ZERO     = 4'h0;
	localparam logic [3:0] OUT_DIV_PRESET = 4'h9;
	// Cascade 96 * 100 * 108 = 1036800, close to 90 MHz / 86.8 Hz
	localparam int         MOD_DIV_A      = 96;
	localparam int         MOD_DIV_B      = 100;
	localparam int         MOD_DIV_C      = 108;
	localparam int         MOD_CNT_WIDTH  = 8;

	// ****************************************
	// Types
	// ****************************************
	typedef logic [DECADE_COUNT-1:0][3:0] tsd_decades_type;

	typedef enum logic [1:0] {
		MODE_TIME_OF_DAY,
		MODE_SCALE_OFFSET_MEASURE,
		MODE_SYNCHRONISE,
		MODE_FREQ_DEVIATION
	} tsd_mode_type;

	typedef enum logic [2:0] {
		MEAS_IDLE,
		MEAS_CLEAR,
		MEAS_PRESET,
		MEAS_ARMED,
		MEAS_GATING,
		MEAS_STORE
	} tsd_meas_state_type;

	typedef struct packed {
		logic gateOpen;
		logic measBusy;
		logic measDone;
		logic syncActive;
	} tsd_status_type;

	typedef struct packed {
		logic                     refSquare;
		logic [MOD_CNT_WIDTH-1:0] modPhase;
	} tsd_modulation_type;

endpackage

// File: tsd_chk.sv
// Purpose: Port assertions for the time-scale divider
// Assumes: refTick and hfTick strobes; edges with ce low are not counted
// Notes:   Bound to every divider instance
`timescale 1ns/1ps

module tsd_chk
	import tsd_pkg::*;
#(
	parameter int DECADES = 7,
	parameter int DIV_A   = 96,
	parameter int DIV_B   = 100,
	parameter int DIV_C   = 108
) (
	input wire logic                       clock,
	input wire logic                       rst_n,
	input wire logic                       ce,
	input wire tsd_pkg::tsd_mode_type      mode,
	input wire logic                       pulseSourceSelect,
	input wire logic                       refTick,
	input wire logic                       hfTick,
	input wire logic                       extPulse,
	input wire logic                       mainScalePulse,
	input wire logic                       auxScalePulse,
	input wire logic                       timeCounterTick,
	input wire logic [DECADES*4-1:0]       displayValue,
	input wire tsd_pkg::tsd_status_type    status,
	input wire tsd_pkg::tsd_modulation_type modulation
);
	// ****************************************
	// Helper counters and assertions
	// ****************************************
	localparam int AUXN = 10 ** DECADES;
	localparam int MODN = DIV_A * DIV_B * DIV_C;
	int   auxCnt;
	int   hfCnt;
	logic seenRise;

	always_ff @(posedge clock) begin
		if (!rst_n || auxScalePulse)
			auxCnt <= int'(rst_n && ce && refTick);
		else if (ce && refTick)
			auxCnt <= auxCnt + 1;
	end

	// First rise after reset has no full period behind it
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hfCnt <= 0;
			seenRise <= 1'b0;
		end else if ($rose(modulation.refSquare)) begin
			hfCnt <= int'(ce && hfTick);
			seenRise <= 1'b1;
		end else if (ce && hfTick) begin
			hfCnt <= hfCnt + 1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	aux_period_a: assert property (auxScalePulse |-> auxCnt == AUXN)
		else $error("aux scale period wrong");
	tod_tick_a: assert property (timeCounterTick == (mainScalePulse && $past(mode) == MODE_TIME_OF_DAY))
		else $error("time counter tick wrong");
	gate_open_a: assert property (mode != MODE_FREQ_DEVIATION && $past(mode) != MODE_FREQ_DEVIATION
		&& $past(mode, 2) != MODE_FREQ_DEVIATION && $past(rst_n, 2) |-> status.gateOpen)
		else $error("gate closed outside deviation mode");
	store_after_a: assert property ($fell(status.gateOpen) && mode == MODE_FREQ_DEVIATION
		&& $past(mode, 6) == MODE_FREQ_DEVIATION |-> ##[1:4] status.measDone)
		else $error("no store after gate end");
	closed_after_a: assert property (status.measDone && mode == MODE_FREQ_DEVIATION |-> !status.gateOpen [*3])
		else $error("gate reopened too soon");
	offset_hold_a: assert property ($changed(displayValue) && mode == MODE_SCALE_OFFSET_MEASURE
		&& $past(mode, 4) == MODE_SCALE_OFFSET_MEASURE && !pulseSourceSelect && !$past(pulseSourceSelect, 4)
		|-> $past(extPulse, 4))
		else $error("display changed without capture");
	sync_len_a: assert property ($rose(status.syncActive) |-> status.syncActive [*8])
		else $error("sync hold too short");
	mod_period_a: assert property ($rose(modulation.refSquare) && seenRise |-> hfCnt == MODN)
		else $error("modulation period wrong");
endmodule

bind tsd_time_scale_divider tsd_chk #(.DECADES(DECADES), .DIV_A(DIV_A), .DIV_B(DIV_B), .DIV_C(DIV_C)) chk (
	.clock(clock), .rst_n(rst_n), .ce(ce), .mode(mode), .pulseSourceSelect(pulseSourceSelect),
	.refTick(refTick), .hfTick(hfTick), .extPulse(extPulse), .mainScalePulse(mainScalePulse),
	.auxScalePulse(auxScalePulse), .timeCounterTick(timeCounterTick), .displayValue(displayValue),
	.status(status), .modulation(modulation));

// File: tsd_pulse_source.sv
// Purpose: Far side: external scale pulse and deviation multiplier output
// Assumes: Driven at the falling clock edge
// Notes:   Pins idle low, as a terminated pulse line would
`timescale 1ns/1ps

module tsd_pulse_source (
	input  wire logic       clock,
	input  wire logic [7:0] period,
	output logic            extPulse,
	output logic            multPulse
);
	// ****************************************
	// Pulse generation
	// ****************************************
	int phase = 0;

	initial begin
		extPulse = 1'b0;
		multPulse = 1'b0;
	end

	// Three cycles high so the three-flop synchroniser cannot miss it
	task automatic fireExt();
		extPulse <= 1'b1;
		repeat (3) @(negedge clock);
		extPulse <= 1'b0;
	endtask

	always @(negedge clock) begin
		phase = (period == 8'h00 || phase + 1 >= int'(period)) ? 0 : phase + 1;
		multPulse <= period != 8'h00 && phase < 2;
	end
endmodule

// File: tsd_time_scale_divider_bench.sv
// Purpose: Self-checking bench for the time-scale divider
// Assumes: Four decades and a short modulation cascade keep the run short
// Notes:   refTick and hfTick held high; ce drops once to prove the freeze
`timescale 1ns/1ps
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tsd_time_scale_divider_bench;
	import tsd_pkg::*;
	// ****************************************
	// Bench
	// ****************************************
	localparam int D = 4;
	localparam int N = 10 ** D;
	logic               clock;
	logic               rst_n;
	logic               ce;
	tsd_mode_type       mode;
	logic               src;
	logic [23:0]        tcv;
	logic [7:0]         period;
	logic               extPulse;
	logic               multPulse;
	logic               mainScalePulse;
	logic               auxScalePulse;
	logic               timeCounterTick;
	logic [4*D-1:0]     displayValue;
	tsd_status_type     status;
	tsd_modulation_type modulation;
	int                 miscompares = 0;
	int                 numChecks = 0;

	tsd_time_scale_divider #(.DECADES(D), .DIV_A(2), .DIV_B(3), .DIV_C(4)) uut (
		.clock(clock), .rst_n(rst_n), .ce(ce), .mode(mode), .pulseSourceSelect(src), .refTick(1'b1),
		.hfTick(1'b1), .extPulse(extPulse), .multPulse(multPulse), .timeCounterValue(tcv),
		.mainScalePulse(mainScalePulse), .auxScalePulse(auxScalePulse), .timeCounterTick(timeCounterTick),
		.displayValue(displayValue), .status(status), .modulation(modulation));
	tsd_pulse_source pulses (.clock(clock), .period(period), .extPulse(extPulse), .multPulse(multPulse));

	function automatic int toInt(input logic [4*D-1:0] v);
		int r = 0;
		for (int i = D - 1; i >= 0; i--)
			r = r * 10 + int'(v[4*i+:4]);
		return r;
	endfunction

	function automatic logic [4*D-1:0] toBcd(input int n);
		logic [4*D-1:0] r;
		for (int i = 0; i < D; i++) begin
			r[4*i+:4] = 4'(n % 10);
			n = n / 10;
		end
		return r;
	endfunction

	task automatic results();
		if (miscompares == 0 && numChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic waitFor(input int sel, output int c);
		for (c = 1; c <= 3 * N; c++) begin
			@(negedge clock);
			if ((sel == 0 && mainScalePulse === 1'b1) || (sel == 1 && auxScalePulse === 1'b1)
				|| (sel == 2 && status.measDone === 1'b1))
				return;
		end
		miscompares++;
		results();
	endtask

	task automatic tod();
		int c;
		tcv = 24'h235959;
		waitFor(0, c);
		`CHK(timeCounterTick, 1'b1)
		`CHK(displayValue, tcv[4*D-1:0])
	endtask

	task automatic offset();
		logic [4*D-1:0] v;
		int c;
		mode = MODE_SCALE_OFFSET_MEASURE;
		repeat (8) @(negedge clock);
		pulses.fireExt();
		repeat (3) @(negedge clock);
		v = displayValue;
		repeat (31) @(negedge clock);
		pulses.fireExt();
		repeat (3) @(negedge clock);
		`CHK(displayValue, toBcd((toInt(v) + 37) % N))
		v = displayValue;
		repeat (40) @(negedge clock);
		`CHK(displayValue, v)
		src = 1'b1;
		pulses.fireExt();
		repeat (6) @(negedge clock);
		`CHK(displayValue, v)
		waitFor(1, c);
		repeat (4) @(negedge clock);
		`CHK(displayValue !== v, 1'b1)
	endtask

	// Of the 37 edges between the two captures, 20 are frozen and must not count
	task automatic freeze();
		logic [4*D-1:0]     v;
		tsd_status_type     s;
		tsd_modulation_type m;
		src = 1'b0;
		pulses.fireExt();
		repeat (3) @(negedge clock);
		v = displayValue;
		repeat (10) @(negedge clock);
		ce = 1'b0;
		repeat (2) @(negedge clock);
		s = status;
		m = modulation;
		repeat (18) @(negedge clock);
		`CHK(status, s)
		`CHK(modulation, m)
		ce = 1'b1;
		@(negedge clock);
		pulses.fireExt();
		repeat (3) @(negedge clock);
		`CHK(displayValue, toBcd((toInt(v) + 17) % N))
	endtask

	// Without the sync the next wrap would come about 3000 cycles early
	task automatic sync();
		int c;
		mode = MODE_SYNCHRONISE;
		src = 1'b0;
		waitFor(0, c);
		repeat (3000) @(negedge clock);
		pulses.fireExt();
		waitFor(0, c);
		`CHK(c >= N - 3 && c <= N + 25, 1'b1)
	endtask

	task automatic freq();
		int c;
		mode = MODE_FREQ_DEVIATION;
		for (int p = 50; p >= 49; p--) begin
			period = 8'(p);
			waitFor(2, c);
			waitFor(2, c);
			repeat (3) @(negedge clock);
			`CHK(displayValue, toBcd(10 * p))
			`CHK(status.measBusy, 1'b0)
		end
	endtask

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		mode = MODE_TIME_OF_DAY;
		src = 1'b0;
		tcv = 24'h000000;
		period = 8'h00;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		tod();
		offset();
		freeze();
		sync();
		freq();
		results();
	end
endmodule
